// file: inc/ssw_defs.vh
// Purpose: constants for the supply supervisor with watchdog reset
// Assumes: 50 MHz clock, times given in their own units
// Notes:   definitions only
`ifndef SSW_DEFS_VH
`define SSW_DEFS_VH

// ==========================================================
// clock and times
`define SSW_CLK_HZ        50000000
`define SSW_RELEASE_MS    180
`define SSW_WDOG_MS       1400
`define SSW_TRIP_US       10
`define SSW_MAN_NS        100

// ==========================================================
// derived cycle counts (one millisecond tick drives the timers)
`define SSW_TICK_CYC      (`SSW_CLK_HZ / 1000)
`define SSW_RELEASE_TICKS `SSW_RELEASE_MS
`define SSW_WDOG_TICKS    `SSW_WDOG_MS
`define SSW_TRIP_CYC      ((`SSW_TRIP_US * (`SSW_CLK_HZ / 1000000)))
`define SSW_MAN_CYC       ((`SSW_MAN_NS * (`SSW_CLK_HZ / 1000000)) / 1000)

// ==========================================================
// widths and reset values
`define SSW_TICK_W        16
`define SSW_CNT_W         12
`define SSW_RST_N_INIT    1'b0

`endif

// file: core/ssw_timer.v
// Purpose: clearable tick counter with terminal flag
// Assumes: synchronous inputs, one clock
// Notes:   done_q stays high from the terminal count until clr or rst
`timescale 1ns/1ps

module ssw_timer #(
  parameter W    = 12,
  parameter TERM = 180
) (
  // clock and reset
  input  wire         clk,
  input  wire         rst,
  // control
  input  wire         clr,
  input  wire         tick,
  // status
  output reg          done_q
);

  reg [W-1:0] cnt_q;
  localparam [W-1:0] TERM_W = TERM[W-1:0];

  // ==========================================================
  // counter
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q  <= {W{1'b0}};
      done_q <= 1'b0;
    end else if (clr) begin
      cnt_q  <= {W{1'b0}};
      done_q <= 1'b0;
    end else if (tick && !done_q) begin
      cnt_q  <= cnt_q + {{(W-1){1'b0}}, 1'b1};
      done_q <= (cnt_q + {{(W-1){1'b0}}, 1'b1}) == TERM_W;
    end
  end

endmodule // ssw_timer

// file: core/ssw_supervisor.v
// Purpose: supply supervisor reset generator with watchdog
// Assumes: supply_ok from an external comparator with hysteresis,
//          all inputs synchronous to clk
// Notes:   outputs registered, so every path adds one clock
`timescale 1ns/1ps
`include "ssw_defs.vh"

module ssw_supervisor #(
  parameter TICK_CYC      = `SSW_TICK_CYC,
  parameter RELEASE_TICKS = `SSW_RELEASE_TICKS,
  parameter WDOG_TICKS    = `SSW_WDOG_TICKS,
  parameter WDOG_EN       = 1
) (
  // clock and reset
  input  wire         clk,
  input  wire         rst,
  // monitored inputs
  input  wire         supply_ok,
  input  wire         manual_reset_in_n,
  input  wire         watchdog_kick_in,
  // reset outputs
  output reg          reset_out_n,
  output reg          reset_out,
  // status
  output reg          wdog_fired_q
);

  // ==========================================================
  // states
  localparam [1:0] ST_HOLD = 2'b00;
  localparam [1:0] ST_RUN  = 2'b01;

  reg [1:0]              state_q;
  reg [1:0]              state_d;
  reg [`SSW_TICK_W-1:0]  pre_q;
  reg                    tick_q;
  reg                    kick_q;
  reg                    kick_seen_q;
  wire                   kick_edge;
  wire                   rel_done;
  wire                   wdog_done;
  wire                   force_rst;
  wire                   rel_clr;
  wire                   wdog_clr;
  wire                   wdog_fire;

  // cut to the prescaler width on purpose; TICK_CYC must fit in it
  localparam integer           TICK_LAST_I = TICK_CYC - 1;
  localparam [`SSW_TICK_W-1:0] TICK_LAST   = TICK_LAST_I[`SSW_TICK_W-1:0];

  // ==========================================================
  // timebase: one-cycle tick every TICK_CYC clocks
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_q  <= {`SSW_TICK_W{1'b0}};
      tick_q <= 1'b0;
    end else if (pre_q == TICK_LAST) begin
      pre_q  <= {`SSW_TICK_W{1'b0}};
      tick_q <= 1'b1;
    end else begin
      pre_q  <= pre_q + {{(`SSW_TICK_W-1){1'b0}}, 1'b1};
      tick_q <= 1'b0;
    end
  end

  // ==========================================================
  // kick edge detect; first sample after reset is not an edge
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      kick_q      <= 1'b0;
      kick_seen_q <= 1'b0;
    end else begin
      kick_q      <= watchdog_kick_in;
      kick_seen_q <= 1'b1;
    end
  end

  assign kick_edge = kick_seen_q && (kick_q != watchdog_kick_in);

  // ==========================================================
  // reset causes
  assign force_rst = !supply_ok || !manual_reset_in_n;

  // release delay restarts whenever a cause is present
  assign rel_clr = force_rst || (state_q == ST_RUN);

  // watchdog only runs while released; restarted on kick or timeout
  assign wdog_clr = (WDOG_EN == 0) || kick_edge ||
                    (state_q != ST_RUN);

  ssw_timer #(
    .W    (`SSW_CNT_W),
    .TERM (RELEASE_TICKS)
  ) u_rel (
    .clk    (clk),
    .rst    (rst),
    .clr    (rel_clr),
    .tick   (tick_q),
    .done_q (rel_done)
  );

  ssw_timer #(
    .W    (`SSW_CNT_W),
    .TERM (WDOG_TICKS)
  ) u_wdog (
    .clk    (clk),
    .rst    (rst),
    .clr    (wdog_clr),
    .tick   (tick_q),
    .done_q (wdog_done)
  );

  // timeout while released and no other cause in the same clock
  assign wdog_fire = (state_q == ST_RUN) && !force_rst &&
                     wdog_done;

  // ==========================================================
  // release decision, shared by both reset outputs
  function released_f;
    input       cause;
    input [1:0] st_next;
    begin
      released_f = !cause && (st_next == ST_RUN);
    end
  endfunction

  // ==========================================================
  // state machine
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_HOLD: begin
        if (!force_rst && rel_done)
          state_d = ST_RUN;
      end
      ST_RUN: begin
        if (force_rst)
          state_d = ST_HOLD;
        else if (wdog_done)
          state_d = ST_HOLD;
      end
      default: state_d = ST_HOLD;
    endcase
  end

  // ==========================================================
  // state register
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_HOLD;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // reset outputs
  // both come from one decision so they never disagree, even for
  // one clock; the price is one clock of latency on every path
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reset_out_n <= `SSW_RST_N_INIT;
      reset_out   <= ~`SSW_RST_N_INIT;
    end else begin
      reset_out_n <= released_f(force_rst, state_d);
      reset_out   <= !released_f(force_rst, state_d);
    end
  end

  // ==========================================================
  // watchdog cause flag
  // set only on the timeout itself; a supply or manual cause in the
  // same clock wins, so the flag never blames the watchdog wrongly
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wdog_fired_q <= 1'b0;
    end else if (wdog_fire) begin
      wdog_fired_q <= 1'b1;
    end else if (state_d == ST_RUN) begin
      wdog_fired_q <= 1'b0;
    end
  end

endmodule // ssw_supervisor

// file: test/ssw_chk.sv
// Purpose: port checker for ssw_supervisor
// Assumes: one clock, async active-high rst
// Notes:   counters measure hold and kick gaps
`timescale 1ns/1ps
// ====
module ssw_chk #(
  parameter TICK_CYC      = 10,
  parameter RELEASE_TICKS = 5,
  parameter WDOG_TICKS    = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic supply_ok,
  input wire logic manual_reset_in_n,
  input wire logic watchdog_kick_in,
  input wire logic reset_out_n,
  input wire logic reset_out,
  input wire logic wdog_fired_q
);
  logic [15:0] rc_q;
  logic [15:0] kc_q;
  logic        kick_q;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // hold length and kick gap, in clocks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rc_q   <= '0;
      kc_q   <= '0;
      kick_q <= 1'b0;
    end else begin
      kick_q <= watchdog_kick_in;
      rc_q   <= (supply_ok && manual_reset_in_n && !reset_out_n) ?
                rc_q + 16'h1 : '0;
      kc_q   <= (!reset_out_n || kick_q != watchdog_kick_in) ?
                '0 : kc_q + 16'h1;
    end
  end
  supply_low_a: assert property (!supply_ok |=> !reset_out_n)
    else $error("reset not forced by low supply");
  out_compl_a: assert property (reset_out == !reset_out_n)
    else $error("outputs not complementary");
  rel_late_a: assert property (rc_q <= RELEASE_TICKS*TICK_CYC+4)
    else $error("release delay too long");
  rel_early_a: assert property ($rose(reset_out_n) |->
    $past(rc_q) >= (RELEASE_TICKS-1)*TICK_CYC-2)
    else $error("release delay too short");
  man_force_a: assert property (!manual_reset_in_n |=> !reset_out_n)
    else $error("manual input did not force reset");
  wdog_late_a: assert property (kc_q <= WDOG_TICKS*TICK_CYC+2)
    else $error("watchdog timeout missed");
  wdog_hold_a: assert property ($rose(wdog_fired_q) |->
    !reset_out_n [*8])
    else $error("watchdog hold too short");
  rel_cause_a: assert property (reset_out_n |->
    $past(supply_ok) && $past(manual_reset_in_n))
    else $error("reset released with a cause present");
  pwr_up_a: assert property ($fell(rst) |-> !reset_out_n)
    else $error("reset not active after power up");
  c_rel: cover property ($rose(reset_out_n));
  c_wd: cover property ($rose(wdog_fired_q));
  c_man: cover property ($fell(manual_reset_in_n));
endmodule // ssw_chk
bind ssw_supervisor ssw_chk #(.TICK_CYC(TICK_CYC),
  .RELEASE_TICKS(RELEASE_TICKS), .WDOG_TICKS(WDOG_TICKS)) u_chk (
  .clk(clk), .rst(rst), .supply_ok(supply_ok),
  .manual_reset_in_n(manual_reset_in_n),
  .watchdog_kick_in(watchdog_kick_in), .reset_out_n(reset_out_n),
  .reset_out(reset_out), .wdog_fired_q(wdog_fired_q));

// file: test/ssw_host.sv
// Purpose: host model that kicks the watchdog
// Assumes: kicks only while reset is released
// Notes:   40 clock period, well inside the timeout
`timescale 1ns/1ps
// ====
module ssw_host (
  input  wire logic clk,
  input  wire logic kick_en,
  input  wire logic reset_out_n,
  output logic      kick = 1'b0
);
  logic [5:0] n = '0;
  always @(posedge clk) begin
    n <= n + 6'h1;
    if (kick_en && reset_out_n && n == 6'h27) begin
      kick <= !kick;
      n    <= '0;
    end
  end
endmodule // ssw_host

// file: test/ssw_supervisor_tb.sv
// Purpose: self-checking bench for ssw_supervisor
// Assumes: tick 10 clocks, release 5 ticks, timeout 8 ticks
// Notes:   fixed waits derived from those figures
`timescale 1ns/1ps
// ====
module ssw_supervisor_tb;
  logic clk = 1'b0, rst = 1'b1, sup = 1'b0, man_n = 1'b1, ken = 1'b1;
  logic kick, rn, ro, wf;
  int failures = 0, compares = 0, cyc = 0;
  ssw_supervisor #(.TICK_CYC(10), .RELEASE_TICKS(5), .WDOG_TICKS(8)) uut (
    .clk(clk), .rst(rst), .supply_ok(sup), .manual_reset_in_n(man_n),
    .watchdog_kick_in(kick), .reset_out_n(rn), .reset_out(ro),
    .wdog_fired_q(wf));
  ssw_host u_host (.clk(clk), .kick_en(ken), .reset_out_n(rn), .kick(kick));
  initial forever #10 clk = !clk;
  task wt(input int n); repeat (n) @(posedge clk); endtask
  task chk(input string nm, input logic s, input logic e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %b seen %b", nm, e, s);
    end
  endtask
  task tally_and_finish;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      failures++;
      tally_and_finish;
    end
  end
  task t_power;
    sup <= 1'b1;
    wt(30); chk("rn", rn, 1'b0);
    wt(35); chk("rn", rn, 1'b1);
    chk("ro", ro, 1'b0);
  endtask
  task t_supply;
    sup <= 1'b0;
    wt(2); chk("rn", rn, 1'b0);
    chk("ro", ro, 1'b1);
    sup <= 1'b1;
    wt(25); sup <= 1'b0;
    wt(2); sup <= 1'b1;
    wt(35); chk("rn", rn, 1'b0);
    wt(30); chk("rn", rn, 1'b1);
  endtask
  task t_manual;
    man_n <= 1'b0;
    wt(2); chk("rn", rn, 1'b0);
    man_n <= 1'b1;
    wt(65); chk("rn", rn, 1'b1);
  endtask
  task t_wdog;
    wt(200); chk("rn", rn, 1'b1);
    ken <= 1'b0;
    wt(95); chk("rn", rn, 1'b0);
    chk("wf", wf, 1'b1);
    wt(60); chk("rn", rn, 1'b1);
    chk("wf", wf, 1'b0);
    wt(95); chk("wf", wf, 1'b1);
  endtask
  initial begin
    wt(12); rst <= 1'b0;
    wt(1); t_power; t_supply; t_manual; t_wdog;
    tally_and_finish;
  end
endmodule // ssw_supervisor_tb
